/* File: hw/hbbcc_pkg.sv */
// Package of constants and types for the Head of Bus B configuration control block
package hbbcc_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] HBBCC_REG_CTRL = 8'h00;
    localparam logic [7:0] HBBCC_REG_TIMER = 8'h04;
    localparam logic [7:0] HBBCC_REG_STATUS = 8'h08;
    // CTRL field positions
    localparam int HBBCC_CTRL_CC12_BIT = 0;
    localparam int HBBCC_CTRL_CCD2_BIT = 1;
    // STATUS field positions
    localparam int HBBCC_ST_STATE_LSB = 0;
    localparam int HBBCC_ST_ETS_BIT = 3;
    localparam int HBBCC_ST_HOBB_BIT = 4;
    localparam int HBBCC_ST_LINK_BIT = 5;
    localparam int HBBCC_ST_SWAP_BIT = 6;
    localparam int HBBCC_ST_TS_LSB = 7;
    localparam int HBBCC_ST_CONT_BIT = 9;
    // Values after reset
    localparam logic HBBCC_CC12_RESET = 1'b0;
    localparam logic HBBCC_CCD2_RESET = 1'b1;
    localparam logic [15:0] HBBCC_TIMER_RESET = 16'h0100;
    // Bus identification field values
    localparam logic [1:0] HBBCC_BIF_NONE = 2'h0;
    localparam logic [1:0] HBBCC_BIF_BUS_A = 2'h1;
    localparam logic [1:0] HBBCC_BIF_BUS_B = 2'h2;
    // Head of bus state machine, Gray coded along the usual path
    typedef enum logic [2:0] {
        HBBCC_INITIALIZE = 3'h0,
        HBBCC_HOB_DFLT = 3'h1,
        HBBCC_HOB_WAIT_DFLT = 3'h3,
        HBBCC_HOB_ACTIVE = 3'h2,
        HBBCC_HOB_WAIT_ACTIVE = 3'h6
    } hbbcc_state_t;
    // Head of bus status values
    typedef enum logic [1:0] {
        HBBCC_HOBS_RELAY = 2'h0,
        HBBCC_HOBS_WAITING = 2'h1,
        HBBCC_HOBS_STABLE = 2'h2
    } hbbcc_hobs_t;
    // 125 us timing source choices
    typedef enum logic [1:0] {
        HBBCC_TS_EITHER_BUS = 2'h0,
        HBBCC_TS_EXTERNAL = 2'h1,
        HBBCC_TS_BUS_B = 2'h2,
        HBBCC_TS_NODE_CLOCK = 2'h3
    } hbbcc_ts_t;
endpackage

/* File: hw/hbbcc_top.sv */
// Head of Bus B configuration control state machine with register port
// Functional notes
// - Head of Bus B machine has exactly five states.
// - Default node powers up in HOB_Active, Head of Bus B emits STABLE.
// - CC_1 node powers up in Initialize.
// - In Initialize, output BIF 00 while empty management octets are indicated.
// - CC_1 node stays in Initialize until consistent BIF Bus A or B arrives.
// - Valid BIF assigns port labels and moves Initialize to HOB_Dflt.
// - Leaving Initialize sets the CC_1 flag to NORMAL when head of bus supported.
// - BIF Bus B at port A from HOB_Dflt returns to Initialize.
// - HOB_Dflt keeps Head of Bus B inactive while disabled or link up.
// - Link down, flag normal, BIF Bus A at port A: restart timer, emit WAITING.
// - HOB_Wait_Dflt arbitrates while normal, link down and timer running.
// - Default node honours both flag settings; others need only DISABLED.
// - Flag source is default flag on default node, CC_1 flag otherwise.
// - Default DSGS and HOBS reach Bus A before CC_2 processing.
// - Default node chooses timing source and requests it at port A.
// - Default ETSS reaches Bus A before CC_2 processing.
// - Default node keeps data path continuity when only slot generator runs.
// - Default node selects node clock when link is down, slot generator only, ETS not active.
// - Timer expiry in HOB_Wait_Dflt enters HOB_Active, emitting STABLE.
// - ETS active exactly when ETS status up and flag normal.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module hbbcc_top #(
    parameter bit DEFAULT_NODE = 1'b0,
    parameter bit HOB_SUPPORT = 1'b1,
    parameter int TIMER_WIDTH = 16
) (
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Link and timing status pins
    input wire logic link_status_2_up,
    input wire logic ets_status_up,
    // Received bus identification per physical port
    input wire logic [1:0] bif_rx_p0,
    input wire logic [1:0] bif_rx_p1,
    input wire logic empty_mgmt_ind,
    // Bus identification output
    output logic [1:0] bif_tx,
    output logic bif_tx_en,
    // Default function inputs and received status on Bus B
    input wire logic [1:0] dflt_dsgs,
    input wire logic [1:0] dflt_hobs,
    input wire logic [1:0] dflt_etss,
    input wire logic hob_op_dsg_only,
    input wire logic etss_b_present,
    // Bus A status writes and Bus B head status
    output logic [1:0] bus_a_dsgs,
    output logic [1:0] bus_a_hobs,
    output logic [1:0] bus_a_etss,
    output hbbcc_pkg::hbbcc_hobs_t hobs_b_tx,
    output logic hob_b_active,
    output logic ets_active,
    // Timing source request and data path continuity
    output hbbcc_pkg::hbbcc_ts_t ts_source,
    output logic ts_req,
    output logic path_continuity,
    output logic port_swap
);
    import hbbcc_pkg::*;

    initial begin
        if (TIMER_WIDTH < 2 || TIMER_WIDTH > 32) begin
            $error("TIMER_WIDTH must lie in 2..32");
        end
    end

    hbbcc_state_t state;
    hbbcc_state_t next_state;
    logic link_meta, link_up, ets_meta, ets_up;
    logic cc12_normal, ccd2_normal, flag_normal;
    logic [TIMER_WIDTH-1:0] timer_limit;
    logic [TIMER_WIDTH-1:0] timer_cnt;
    logic timer_restart, timer_expired, timer_running;
    logic [1:0] bif_at_a, bif_at_b;
    logic labels_ok, leave_init, bif_b_at_a;
    logic next_swap;
    hbbcc_ts_t next_ts;

    // Two-stage synchronisers for the status pins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            link_meta <= 1'b0;
            link_up <= 1'b0;
            ets_meta <= 1'b0;
            ets_up <= 1'b0;
        end else if (clk_en) begin
            link_meta <= link_status_2_up;
            link_up <= link_meta;
            ets_meta <= ets_status_up;
            ets_up <= ets_meta;
        end
    end

    // Flag source depends on node role
    assign flag_normal = DEFAULT_NODE ? ccd2_normal : cc12_normal;

    // Control register; hardware set of the CC_1 flag wins over software
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cc12_normal <= HBBCC_CC12_RESET;
            ccd2_normal <= HBBCC_CCD2_RESET;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == HBBCC_REG_CTRL) begin
                cc12_normal <= reg_wdata[HBBCC_CTRL_CC12_BIT];
                ccd2_normal <= reg_wdata[HBBCC_CTRL_CCD2_BIT];
            end
            if (!DEFAULT_NODE && HOB_SUPPORT && leave_init) begin
                cc12_normal <= 1'b1;
            end
        end
    end

    // Timer expiry value register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timer_limit <= TIMER_WIDTH'(HBBCC_TIMER_RESET);
        end else if (clk_en && reg_wr && reg_addr == HBBCC_REG_TIMER) begin
            timer_limit <= reg_wdata[TIMER_WIDTH-1:0];
        end
    end

    // Read data, valid one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (clk_en) begin
            reg_rdata <= 32'h0;
            if (reg_rd) begin
                case (reg_addr)
                    HBBCC_REG_CTRL: begin
                        reg_rdata[HBBCC_CTRL_CC12_BIT] <= cc12_normal;
                        reg_rdata[HBBCC_CTRL_CCD2_BIT] <= ccd2_normal;
                    end
                    HBBCC_REG_TIMER: begin
                        reg_rdata[TIMER_WIDTH-1:0] <= timer_limit;
                    end
                    HBBCC_REG_STATUS: begin
                        reg_rdata[HBBCC_ST_STATE_LSB+:3] <= state;
                        reg_rdata[HBBCC_ST_ETS_BIT] <= ets_active;
                        reg_rdata[HBBCC_ST_HOBB_BIT] <= hob_b_active;
                        reg_rdata[HBBCC_ST_LINK_BIT] <= link_up;
                        reg_rdata[HBBCC_ST_SWAP_BIT] <= port_swap;
                        reg_rdata[HBBCC_ST_TS_LSB+:2] <= ts_source;
                        reg_rdata[HBBCC_ST_CONT_BIT] <= path_continuity;
                    end
                    default: begin
                        reg_rdata <= 32'h0;
                    end
                endcase
            end
        end
    end

    // Arbitration timer: reload on restart, one-cycle expiry at the last count
    assign timer_running = timer_cnt != '0;
    assign timer_expired = clk_en && timer_cnt == TIMER_WIDTH'(1) && !timer_restart;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timer_cnt <= '0;
        end else if (clk_en) begin
            if (timer_restart) begin
                timer_cnt <= timer_limit;
            end else if (timer_running) begin
                timer_cnt <= timer_cnt - TIMER_WIDTH'(1);
            end
        end
    end

    // Port labelling: the port that hears Bus A identification is labelled A
    assign bif_at_a = port_swap ? bif_rx_p1 : bif_rx_p0;
    assign bif_at_b = port_swap ? bif_rx_p0 : bif_rx_p1;
    assign bif_b_at_a = !DEFAULT_NODE && bif_at_a == HBBCC_BIF_BUS_B;
    // Labelling is consistent when some port hears Bus A or B and the two ports do not claim the same bus
    assign labels_ok = (bif_rx_p0 == HBBCC_BIF_BUS_A || bif_rx_p0 == HBBCC_BIF_BUS_B
                        || bif_rx_p1 == HBBCC_BIF_BUS_A || bif_rx_p1 == HBBCC_BIF_BUS_B)
                       && !(bif_rx_p0 != HBBCC_BIF_NONE && bif_rx_p0 == bif_rx_p1);
    assign leave_init = clk_en && state == HBBCC_INITIALIZE && labels_ok;

    always_comb begin
        next_swap = port_swap;
        if (state == HBBCC_INITIALIZE && labels_ok) begin
            next_swap = bif_rx_p1 == HBBCC_BIF_BUS_A || bif_rx_p0 == HBBCC_BIF_BUS_B;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            port_swap <= 1'b0;
        end else if (clk_en) begin
            port_swap <= next_swap;
        end
    end

    // Next state and timer restart for the head of bus machine
    always_comb begin
        next_state = state;
        timer_restart = 1'b0;
        case (state)
            HBBCC_INITIALIZE: begin
                if (labels_ok) begin
                    next_state = HBBCC_HOB_DFLT;
                end
            end
            HBBCC_HOB_DFLT: begin
                if (bif_b_at_a) begin
                    next_state = HBBCC_INITIALIZE;
                end else if (!link_up && flag_normal
                             && (DEFAULT_NODE || bif_at_a == HBBCC_BIF_BUS_A)) begin
                    next_state = HBBCC_HOB_WAIT_DFLT;
                    timer_restart = 1'b1;
                end
            end
            HBBCC_HOB_WAIT_DFLT: begin
                if (bif_b_at_a) begin
                    next_state = HBBCC_INITIALIZE;
                end else if (link_up || !flag_normal) begin
                    next_state = HBBCC_HOB_DFLT;
                end else if (timer_cnt == TIMER_WIDTH'(1)) begin
                    next_state = HBBCC_HOB_ACTIVE;
                end
            end
            HBBCC_HOB_ACTIVE: begin
                if (bif_b_at_a) begin
                    next_state = HBBCC_INITIALIZE;
                end else if (!flag_normal) begin
                    next_state = HBBCC_HOB_DFLT;
                end else if (link_up) begin
                    next_state = HBBCC_HOB_WAIT_ACTIVE;
                    timer_restart = 1'b1;
                end
            end
            HBBCC_HOB_WAIT_ACTIVE: begin
                if (bif_b_at_a) begin
                    next_state = HBBCC_INITIALIZE;
                end else if (timer_cnt == TIMER_WIDTH'(1) || !flag_normal) begin
                    next_state = HBBCC_HOB_DFLT;
                end else if (!link_up) begin
                    next_state = HBBCC_HOB_ACTIVE;
                end
            end
            default: begin
                next_state = HBBCC_HOB_DFLT;
            end
        endcase
    end

    // State register; power-up state follows node role
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= DEFAULT_NODE ? HBBCC_HOB_ACTIVE : HBBCC_INITIALIZE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Head of Bus B resource and its status toward Bus B
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hobs_b_tx <= DEFAULT_NODE ? HBBCC_HOBS_STABLE : HBBCC_HOBS_RELAY;
            hob_b_active <= DEFAULT_NODE;
        end else if (clk_en) begin
            case (next_state)
                HBBCC_HOB_WAIT_DFLT, HBBCC_HOB_WAIT_ACTIVE: begin
                    hobs_b_tx <= HBBCC_HOBS_WAITING;
                    hob_b_active <= 1'b1;
                end
                HBBCC_HOB_ACTIVE: begin
                    hobs_b_tx <= HBBCC_HOBS_STABLE;
                    hob_b_active <= 1'b1;
                end
                default: begin
                    hobs_b_tx <= HBBCC_HOBS_RELAY;
                    hob_b_active <= 1'b0;
                end
            endcase
        end
    end

    // Bus identification output while initializing
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bif_tx <= HBBCC_BIF_NONE;
            bif_tx_en <= 1'b0;
        end else if (clk_en) begin
            bif_tx <= HBBCC_BIF_NONE;
            bif_tx_en <= state == HBBCC_INITIALIZE && empty_mgmt_ind;
        end
    end

    // External timing source machine
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ets_active <= 1'b0;
        end else if (clk_en) begin
            ets_active <= ets_up && flag_normal;
        end
    end

    // Default function writes Bus A status first; CC_2 then reads these registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_a_dsgs <= 2'h0;
            bus_a_hobs <= 2'h0;
            bus_a_etss <= 2'h0;
        end else if (clk_en && DEFAULT_NODE) begin
            bus_a_dsgs <= dflt_dsgs;
            bus_a_hobs <= dflt_hobs;
            bus_a_etss <= dflt_etss;
        end
    end

    // Timing source choice of the default function
    always_comb begin
        if (ets_active) begin
            next_ts = HBBCC_TS_EXTERNAL;
        end else if (hob_op_dsg_only) begin
            next_ts = link_up ? HBBCC_TS_EITHER_BUS : HBBCC_TS_NODE_CLOCK;
        end else if (etss_b_present) begin
            next_ts = HBBCC_TS_BUS_B;
        end else begin
            next_ts = HBBCC_TS_NODE_CLOCK;
        end
    end

    // Timing source request pulses on the default node whenever the choice changes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ts_source <= HBBCC_TS_NODE_CLOCK;
            ts_req <= 1'b0;
            path_continuity <= 1'b0;
        end else if (clk_en) begin
            ts_req <= DEFAULT_NODE && next_ts != ts_source;
            if (DEFAULT_NODE) begin
                ts_source <= next_ts;
            end
            path_continuity <= DEFAULT_NODE && hob_op_dsg_only;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_state_legal: assert property (state inside {HBBCC_INITIALIZE, HBBCC_HOB_DFLT,
        HBBCC_HOB_WAIT_DFLT, HBBCC_HOB_ACTIVE, HBBCC_HOB_WAIT_ACTIVE})
        else $error("illegal head of bus state");
    a_power_up_state: assert property ($rose(reset_n) |-> state == (DEFAULT_NODE ?
        HBBCC_HOB_ACTIVE : HBBCC_INITIALIZE))
        else $error("wrong power-up state");
    a_bif_zero_out: assert property (clk_en && state == HBBCC_INITIALIZE && empty_mgmt_ind
        |=> bif_tx_en && bif_tx == HBBCC_BIF_NONE)
        else $error("BIF 00 not emitted in initialize");
    a_wait_enter_timer: assert property (clk_en && state == HBBCC_HOB_DFLT
        && next_state == HBBCC_HOB_WAIT_DFLT
        |=> timer_cnt == timer_limit && hobs_b_tx == HBBCC_HOBS_WAITING)
        else $error("wait entry without timer restart or WAITING");
    a_dflt_inactive: assert property (state == HBBCC_HOB_DFLT && $past(state) == HBBCC_HOB_DFLT
        |-> !hob_b_active)
        else $error("head of bus active in default state");
    a_expiry_active: assert property (clk_en && state == HBBCC_HOB_WAIT_DFLT && timer_expired
        && flag_normal && !link_up && !bif_b_at_a
        |=> state == HBBCC_HOB_ACTIVE && hobs_b_tx == HBBCC_HOBS_STABLE)
        else $error("expiry did not enter active");
    a_ets_follow: assert property (clk_en |=> ets_active == $past(ets_up && flag_normal))
        else $error("ETS state mismatch");
    a_expiry_single: assert property (timer_expired |=> !timer_expired)
        else $error("timer expiry longer than one cycle");
    a_cc12_set: assert property (leave_init && !DEFAULT_NODE && HOB_SUPPORT
        |=> cc12_normal)
        else $error("CC_1 flag not set to NORMAL");
    a_node_clock: assert property (clk_en && DEFAULT_NODE && !ets_active && hob_op_dsg_only
        && !link_up |=> ts_source == HBBCC_TS_NODE_CLOCK)
        else $error("node clock not selected");

    c_leave_init: cover property (state == HBBCC_INITIALIZE ##1 state == HBBCC_HOB_DFLT);
    c_reach_active: cover property (state == HBBCC_HOB_WAIT_DFLT ##1 state == HBBCC_HOB_ACTIVE);
    c_wait_active_back: cover property (state == HBBCC_HOB_WAIT_ACTIVE
        ##1 state == HBBCC_HOB_ACTIVE);
    c_ts_request: cover property (ts_req);
endmodule

/* File: bench/hbbcc_far_nodes.sv */
// Model of the other nodes on the dual bus as one node sees them
`timescale 1ns/100ps
module hbbcc_far_nodes (
    // Clock
    input wire logic clk_sys,
    // Bench commands
    input wire logic [1:0] cmd_bif_p0,
    input wire logic [1:0] cmd_bif_p1,
    input wire logic cmd_link_up,
    input wire logic cmd_ets_up,
    // Levels presented to the node
    output logic [1:0] bif_rx_p0,
    output logic [1:0] bif_rx_p1,
    output logic link_status_2_up,
    output logic ets_status_up,
    output logic empty_mgmt_ind
);
    // Quiet subnetwork at time zero
    initial begin
        bif_rx_p0 = 2'h0;
        bif_rx_p1 = 2'h0;
        link_status_2_up = 1'b0;
        ets_status_up = 1'b0;
        empty_mgmt_ind = 1'b1;
    end
    // Remote heads answer one cycle after a command
    always @(posedge clk_sys) begin
        bif_rx_p0 <= cmd_bif_p0;
        bif_rx_p1 <= cmd_bif_p1;
        link_status_2_up <= cmd_link_up;
        ets_status_up <= cmd_ets_up;
        // Empty octets until some head sends an identifier
        empty_mgmt_ind <= (cmd_bif_p0 == 2'h0) && (cmd_bif_p1 == 2'h0);
    end
endmodule

/* File: bench/test_hbbcc_top.sv */
// Self-checking bench for a CC_1 node and a default node side by side
`timescale 1ns/100ps
module test_hbbcc_top;
    import hbbcc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] c_p0 = 2'h0;
    logic [1:0] c_p1 = 2'h0;
    logic c_link = 1'b0;
    logic c_ets = 1'b0;
    logic [1:0] dflt_dsgs = 2'h0;
    logic [1:0] dflt_hobs = 2'h0;
    logic [1:0] dflt_etss = 2'h0;
    logic hob_op_dsg_only = 1'b0;
    logic etss_b_present = 1'b0;
    logic [1:0] bif_rx_p0, bif_rx_p1;
    logic link_status_2_up, ets_status_up, empty_mgmt_ind;
    logic [31:0] rdata [2];
    logic [1:0] btx [2], ba_d [2], ba_h [2], ba_e [2];
    logic btx_en [2], hact [2], eact [2], tsr [2], cont [2], swap [2];
    hbbcc_hobs_t hobs_tx [2];
    hbbcc_ts_t tsrc [2];
    logic [31:0] seed = 32'hc9889bfa;
    int tmr;
    int num_errors = 0;
    int n_checks = 0;

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // Far side of both nodes
    hbbcc_far_nodes i_far (
        .clk_sys, .cmd_bif_p0(c_p0), .cmd_bif_p1(c_p1), .cmd_link_up(c_link),
        .cmd_ets_up(c_ets), .bif_rx_p0, .bif_rx_p1, .link_status_2_up,
        .ets_status_up, .empty_mgmt_ind
    );
    // Node 0 holds CC_1, node 1 the default function
    for (genvar g = 0; g < 2; g++) begin : g_node
        hbbcc_top #(.DEFAULT_NODE(g == 1)) i_dut (
            .clk_sys, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
            .reg_rdata(rdata[g]), .link_status_2_up, .ets_status_up, .bif_rx_p0,
            .bif_rx_p1, .empty_mgmt_ind, .bif_tx(btx[g]), .bif_tx_en(btx_en[g]),
            .dflt_dsgs, .dflt_hobs, .dflt_etss, .hob_op_dsg_only, .etss_b_present,
            .bus_a_dsgs(ba_d[g]), .bus_a_hobs(ba_h[g]), .bus_a_etss(ba_e[g]),
            .hobs_b_tx(hobs_tx[g]), .hob_b_active(hact[g]), .ets_active(eact[g]),
            .ts_source(tsrc[g]), .ts_req(tsr[g]), .path_continuity(cont[g]),
            .port_swap(swap[g])
        );
    end

    // Random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read both nodes, compare masked data
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e0, e1);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(rdata[0] & m, e0);
        chk(rdata[1] & m, e1);
    endtask

    task automatic wait_hobs(input int g, input hbbcc_hobs_t v);
        for (int i = 0; i < 60 && hobs_tx[g] !== v; i++) @(negedge clk_sys);
        chk(32'(hobs_tx[g]), 32'(v));
    endtask

    // Length of the WAITING phase against the timer setting
    task automatic wait_len(input int g);
        int n;
        n = 0;
        wait_hobs(g, HBBCC_HOBS_WAITING);
        while (hobs_tx[g] === HBBCC_HOBS_WAITING && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chk(32'(n), 32'(tmr));
    endtask

    // New source must come with its request pulse
    task automatic wait_ts(input hbbcc_ts_t v);
        for (int i = 0; i < 20 && tsrc[1] !== v; i++) @(negedge clk_sys);
        chk(32'(tsrc[1]), 32'(v));
        chk(32'(tsr[1]), 32'h1);
    endtask

    task automatic test_done();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog, the run needs under 2000 cycles
    initial begin
        #150000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk(32'(hobs_tx[1]), 32'(HBBCC_HOBS_STABLE));
        chk(32'(hact[1]), 32'h1);
        chk(32'(hobs_tx[0]), 32'(HBBCC_HOBS_RELAY));
        rd_chk(HBBCC_REG_STATUS, 32'h7, 32'h0, 32'h2);
        rd_chk(HBBCC_REG_CTRL, 32'h3, 32'h2, 32'h2);
        rd_chk(HBBCC_REG_TIMER, 32'hffff, 32'h100, 32'h100);
        rd_chk(8'h0c, 32'hffffffff, 32'h0, 32'h0);
        chk(32'({btx[0], btx_en[0]}), 32'h1);
        seed = lfsr(seed);
        tmr = 4 + int'(seed[3:0]);
        wr(HBBCC_REG_TIMER, 32'(tmr));
        // Default node leaves and regains the head role
        c_link <= 1'b1;
        wait_len(1);
        chk(32'(hact[1]), 32'h0);
        @(posedge clk_sys);
        c_link <= 1'b0;
        wait_len(1);
        wait_hobs(1, HBBCC_HOBS_STABLE);
        // Conflicting identifiers keep the CC_1 node unlabelled
        @(posedge clk_sys);
        c_p0 <= HBBCC_BIF_BUS_A;
        c_p1 <= HBBCC_BIF_BUS_A;
        c_link <= 1'b1;
        repeat (tmr + 8) @(posedge clk_sys);
        rd_chk(HBBCC_REG_STATUS, 32'h7, 32'h0, 32'h1);
        @(posedge clk_sys);
        c_p0 <= HBBCC_BIF_NONE;
        repeat (8) @(posedge clk_sys);
        chk(32'(swap[0]), 32'h1);
        rd_chk(HBBCC_REG_STATUS, 32'h7, 32'h1, 32'h1);
        rd_chk(HBBCC_REG_CTRL, 32'h3, 32'h3, 32'h2);
        @(posedge clk_sys);
        c_link <= 1'b0;
        wait_len(0);
        wait_hobs(0, HBBCC_HOBS_STABLE);
        // Bus B at the A port
        @(posedge clk_sys);
        c_p0 <= HBBCC_BIF_BUS_B;
        c_p1 <= HBBCC_BIF_BUS_B;
        wait_hobs(0, HBBCC_HOBS_RELAY);
        rd_chk(HBBCC_REG_STATUS, 32'h7, 32'h0, 32'h2);
        // Each node follows its own flag
        @(posedge clk_sys);
        c_ets <= 1'b1;
        wr(HBBCC_REG_CTRL, 32'h1);
        wait_hobs(1, HBBCC_HOBS_RELAY);
        repeat (6) @(negedge clk_sys);
        chk(32'(eact[0]), 32'h1);
        chk(32'(eact[1]), 32'h0);
        wr(HBBCC_REG_CTRL, 32'h2);
        wait_ts(HBBCC_TS_EXTERNAL);
        @(posedge clk_sys);
        c_ets <= 1'b0;
        hob_op_dsg_only <= 1'b1;
        wait_ts(HBBCC_TS_NODE_CLOCK);
        chk(32'(cont[1]), 32'h1);
        @(posedge clk_sys);
        c_link <= 1'b1;
        wait_ts(HBBCC_TS_EITHER_BUS);
        @(posedge clk_sys);
        hob_op_dsg_only <= 1'b0;
        etss_b_present <= 1'b1;
        wait_ts(HBBCC_TS_BUS_B);
        // Strobes are lost while the enable is low
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(HBBCC_REG_CTRL, 32'h0);
        clk_en <= 1'b1;
        rd_chk(HBBCC_REG_CTRL, 32'h3, 32'h2, 32'h2);
        // Random default status values, one cycle to Bus A
        repeat (40) begin
            @(posedge clk_sys);
            seed = lfsr(seed);
            dflt_dsgs <= seed[1:0];
            dflt_hobs <= seed[3:2];
            dflt_etss <= seed[5:4];
            @(posedge clk_sys);
            #1;
            chk(32'({ba_d[1], ba_h[1], ba_e[1]}), 32'({seed[1:0], seed[3:2], seed[5:4]}));
            chk(32'({ba_d[0], ba_h[0], ba_e[0]}), 32'h0);
        end
        test_done();
    end
endmodule
